// file: verilog/astsb_pkg.sv
// constants, field layouts and carrier types of the accel sample/time/status bank
// Summary of operation
// (RQ1) timestamp low byte counts 39.0625 us steps
// (RQ2) timestamp middle byte counts 10 ms steps
// (RQ3) timestamp high byte counts 2.56 s steps
// (RQ4) power-up flag set at reset, cleared on read
// (RQ5) feature status bits 7,6,5; whole register read-clears
// (RQ6) any accel data read clears sample-ready
// (RQ7) each axis 16 bits, low byte lower address
package astsb_pkg;

  // =====================================================================
  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_ACC_X_LO = 8'h12;
  localparam logic [ADDR_W-1:0] ADDR_ACC_X_HI = 8'h13;
  localparam logic [ADDR_W-1:0] ADDR_ACC_Y_LO = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ACC_Y_HI = 8'h15;
  localparam logic [ADDR_W-1:0] ADDR_ACC_Z_LO = 8'h16;
  localparam logic [ADDR_W-1:0] ADDR_ACC_Z_HI = 8'h17;
  localparam logic [ADDR_W-1:0] ADDR_TS_LO = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_TS_MID = 8'h19;
  localparam logic [ADDR_W-1:0] ADDR_TS_HI = 8'h1A;
  localparam logic [ADDR_W-1:0] ADDR_POWER_UP_EVENT = 8'h1B;
  localparam logic [ADDR_W-1:0] ADDR_FEAT_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h30;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'h31;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'h32;
  localparam logic [ADDR_W-1:0] ADDR_SOFT_RESET = 8'h33;

  localparam logic [DATA_W-1:0] SOFT_RESET_KEY = 8'h5A;
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;

  // =====================================================================
  // field layouts
  localparam int ACC_BYTES = 6;
  localparam int ACC_IDX_W = 3;
  localparam int POR_BIT = 0;
  localparam logic POR_RESET = 1'b1;
  localparam int FEAT_ERR_BIT = 7;
  localparam int FEAT_NOMO_BIT = 6;
  localparam int FEAT_ANYMO_BIT = 5;

  localparam int IRQ_W = 5;
  localparam int IRQ_DRDY_BIT = 0;
  localparam int IRQ_ANYMO_BIT = 1;
  localparam int IRQ_NOMO_BIT = 2;
  localparam int IRQ_ERR_BIT = 3;
  localparam int IRQ_POR_BIT = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 5'h00;

  // =====================================================================
  // timing
  localparam int CLK_PERIOD_PS = 10000;
  localparam int TS_LSB_PS = 39062500;
  localparam int TS_MID_NS = 10000000;
  localparam int TS_HIGH_US = 2560000;
  localparam int TS_W = 24;
  localparam int TS_ACC_W = 27;
  localparam int TS_GAP_W = 16;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } astsb_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } astsb_sample_t;

  typedef struct packed {
    logic error;
    logic no_motion;
    logic any_motion;
  } astsb_feat_t;

endpackage

// file: verilog/astsb_timestamp.sv
// free-running 24-bit sensor timestamp with exact fractional step
`timescale 1ns/10ps
`default_nettype none

module astsb_timestamp #(
  parameter int LSB_PS = astsb_pkg::TS_LSB_PS
) (
  input wire logic clock, // system clock
  input wire logic sys_rst, // async reset, active high
  input wire logic soft_rst, // one-cycle restart of the count
  output logic [astsb_pkg::TS_W-1:0] count, // timestamp value
  output logic tick // one-cycle pulse per low-byte step
);

  localparam int GAP_LO = LSB_PS / astsb_pkg::CLK_PERIOD_PS;
  localparam int GAP_HI = GAP_LO + 1;

  // =====================================================================
  // phase accumulator in picoseconds: the step is not a whole number of
  // cycles, so single steps jitter by one cycle but never drift
  logic [astsb_pkg::TS_ACC_W-1:0] acc_ff;
  logic [astsb_pkg::TS_W-1:0] count_ff;
  logic [astsb_pkg::TS_ACC_W-1:0] acc_sum;
  logic step;
  logic [astsb_pkg::TS_ACC_W-1:0] nxt_acc;
  logic [astsb_pkg::TS_W-1:0] nxt_count;

  assign acc_sum = acc_ff + astsb_pkg::TS_ACC_W'(astsb_pkg::CLK_PERIOD_PS);
  assign step = acc_sum >= astsb_pkg::TS_ACC_W'(LSB_PS); // RQ1
  assign nxt_acc = soft_rst ? '0 : (step ? acc_sum - astsb_pkg::TS_ACC_W'(LSB_PS) : acc_sum);
  // mid and high bytes are the carry chain of the same counter, so their
  // weights are 256 and 65536 low-byte steps
  assign nxt_count = soft_rst ? '0 : count_ff + astsb_pkg::TS_W'(step); // RQ2 RQ3

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      acc_ff <= '0;
      count_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      count_ff <= nxt_count;
    end
  end

  assign count = count_ff;
  assign tick = step & ~soft_rst;

  // =====================================================================
  // checking helpers
  logic [astsb_pkg::TS_GAP_W-1:0] gap_ff;
  logic seen_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gap_ff <= '0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= (tick | soft_rst) ? '0 : gap_ff + 1'b1;
      seen_ff <= soft_rst ? 1'b0 : (seen_ff | tick);
    end
  end

  a_ts_tick_gap: assert property (@(posedge clock) disable iff (sys_rst) // RQ1
    (tick && seen_ff) |-> (int'(gap_ff) + 1 >= GAP_LO && int'(gap_ff) + 1 <= GAP_HI))
    else $error("timestamp step spacing wrong");

  a_ts_mid_carry: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
    ($changed(count_ff[15:8]) && !$past(soft_rst)) |-> ($past(count_ff[7:0]) == 8'hFF))
    else $error("timestamp middle byte moved without low byte wrap");

  a_ts_high_carry: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
    ($changed(count_ff[23:16]) && !$past(soft_rst)) |-> ($past(count_ff[15:0]) == 16'hFFFF))
    else $error("timestamp high byte moved without middle byte wrap");

endmodule

`default_nettype wire

// file: verilog/astsb_bank.sv
// read-only accel sample, timestamp and status register bank with interrupt
`timescale 1ns/10ps
`default_nettype none

module astsb_bank #(
  parameter int TS_LSB_PS = astsb_pkg::TS_LSB_PS
) (
  input wire logic clock, // system clock, 100 MHz
  input wire logic sys_rst, // async reset, active high
  input wire astsb_pkg::astsb_req_t bus_req, // register request
  output logic [astsb_pkg::DATA_W-1:0] bus_rdata, // read data, cycle after read
  input wire astsb_pkg::astsb_sample_t sample_in, // new acceleration sample
  input wire astsb_pkg::astsb_feat_t feat_in, // feature event pulses
  output logic sample_ready, // new sample not yet read
  output logic irq // enabled status pending
);

  // =====================================================================
  // address decode
  function automatic logic is_acc_addr(input logic [astsb_pkg::ADDR_W-1:0] a);
    is_acc_addr = (a >= astsb_pkg::ADDR_ACC_X_LO) && (a <= astsb_pkg::ADDR_ACC_Z_HI);
  endfunction

  logic rd_acc;
  logic rd_por;
  logic rd_feat;
  logic wr_clear;
  logic wr_enable;
  logic soft_rst;
  logic [astsb_pkg::ADDR_W-1:0] acc_off;
  logic [astsb_pkg::ACC_IDX_W-1:0] acc_idx;

  assign rd_acc = bus_req.rd && is_acc_addr(bus_req.addr); // RQ6
  assign rd_por = bus_req.rd && (bus_req.addr == astsb_pkg::ADDR_POWER_UP_EVENT); // RQ4
  assign rd_feat = bus_req.rd && (bus_req.addr == astsb_pkg::ADDR_FEAT_STATUS); // RQ5
  assign wr_clear = bus_req.wr && (bus_req.addr == astsb_pkg::ADDR_IRQ_CLEAR);
  assign wr_enable = bus_req.wr && (bus_req.addr == astsb_pkg::ADDR_IRQ_ENABLE);
  assign soft_rst = bus_req.wr && (bus_req.addr == astsb_pkg::ADDR_SOFT_RESET)
    && (bus_req.wdata == astsb_pkg::SOFT_RESET_KEY);
  assign acc_off = bus_req.addr - astsb_pkg::ADDR_ACC_X_LO;
  assign acc_idx = acc_off[astsb_pkg::ACC_IDX_W-1:0];

  // =====================================================================
  // timestamp
  logic [astsb_pkg::TS_W-1:0] ts_count;

  astsb_timestamp #(
    .LSB_PS(TS_LSB_PS)
  ) u_timestamp (
    .clock(clock),
    .sys_rst(sys_rst),
    .soft_rst(soft_rst),
    .count(ts_count),
    .tick()
  );

  // =====================================================================
  // acceleration sample storage, byte indexed
  logic [astsb_pkg::DATA_W-1:0] acc_ff [astsb_pkg::ACC_BYTES];
  logic [astsb_pkg::DATA_W-1:0] acc_load [astsb_pkg::ACC_BYTES];

  // low byte at the even (lower) address, high byte above it
  assign acc_load[0] = sample_in.x[7:0]; // RQ7
  assign acc_load[1] = sample_in.x[15:8]; // RQ7
  assign acc_load[2] = sample_in.y[7:0]; // RQ7
  assign acc_load[3] = sample_in.y[15:8]; // RQ7
  assign acc_load[4] = sample_in.z[7:0]; // RQ7
  assign acc_load[5] = sample_in.z[15:8]; // RQ7

  genvar gi;
  generate
    for (gi = 0; gi < astsb_pkg::ACC_BYTES; gi++) begin : g_acc
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          acc_ff[gi] <= astsb_pkg::RST_ZERO;
        end else if (sample_in.valid) begin
          acc_ff[gi] <= acc_load[gi];
        end
      end
    end
  endgenerate

  // =====================================================================
  // flags: in every flag an event in the clearing cycle wins
  logic drdy_ff;
  logic por_ff;
  logic [astsb_pkg::DATA_W-1:0] feat_ff;
  logic [astsb_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [astsb_pkg::IRQ_W-1:0] irq_en_ff;
  logic nxt_drdy;
  logic nxt_por;
  logic [astsb_pkg::DATA_W-1:0] feat_set;
  logic [astsb_pkg::DATA_W-1:0] nxt_feat;
  logic [astsb_pkg::IRQ_W-1:0] irq_set;
  logic [astsb_pkg::IRQ_W-1:0] irq_clr;
  logic [astsb_pkg::IRQ_W-1:0] nxt_irq_stat;
  logic [astsb_pkg::IRQ_W-1:0] nxt_irq_en;

  assign nxt_drdy = sample_in.valid | (drdy_ff & ~rd_acc); // RQ6
  assign nxt_por = soft_rst | (por_ff & ~rd_por); // RQ4

  always_comb begin
    feat_set = astsb_pkg::RST_ZERO;
    feat_set[astsb_pkg::FEAT_ERR_BIT] = feat_in.error; // RQ5
    feat_set[astsb_pkg::FEAT_NOMO_BIT] = feat_in.no_motion; // RQ5
    feat_set[astsb_pkg::FEAT_ANYMO_BIT] = feat_in.any_motion; // RQ5
  end

  // the whole register empties on read, reserved bits never set
  assign nxt_feat = feat_set | (rd_feat ? astsb_pkg::RST_ZERO : feat_ff); // RQ5

  always_comb begin
    irq_set = '0;
    irq_set[astsb_pkg::IRQ_DRDY_BIT] = sample_in.valid;
    irq_set[astsb_pkg::IRQ_ANYMO_BIT] = feat_in.any_motion;
    irq_set[astsb_pkg::IRQ_NOMO_BIT] = feat_in.no_motion;
    irq_set[astsb_pkg::IRQ_ERR_BIT] = feat_in.error;
    irq_set[astsb_pkg::IRQ_POR_BIT] = soft_rst;
  end

  assign irq_clr = wr_clear ? bus_req.wdata[astsb_pkg::IRQ_W-1:0] : '0;
  assign nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);
  assign nxt_irq_en = wr_enable ? bus_req.wdata[astsb_pkg::IRQ_W-1:0] : irq_en_ff;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      drdy_ff <= 1'b0;
      por_ff <= astsb_pkg::POR_RESET; // RQ4
      feat_ff <= astsb_pkg::RST_ZERO;
      irq_stat_ff <= astsb_pkg::IRQ_RESET;
      irq_en_ff <= astsb_pkg::IRQ_RESET;
    end else begin
      drdy_ff <= nxt_drdy;
      por_ff <= nxt_por;
      feat_ff <= nxt_feat;
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff <= nxt_irq_en;
    end
  end

  assign sample_ready = drdy_ff;
  assign irq = |(irq_stat_ff & irq_en_ff);

  // =====================================================================
  // read mux; unmapped and write-only addresses read as zero
  logic [astsb_pkg::DATA_W-1:0] rd_mux;
  logic [astsb_pkg::DATA_W-1:0] por_word;
  logic [astsb_pkg::DATA_W-1:0] rdata_ff;

  always_comb begin
    por_word = astsb_pkg::RST_ZERO;
    por_word[astsb_pkg::POR_BIT] = por_ff;
  end

  always_comb begin
    rd_mux = astsb_pkg::RST_ZERO;
    if (is_acc_addr(bus_req.addr)) begin
      rd_mux = acc_ff[acc_idx]; // RQ7
    end else begin
      case (bus_req.addr)
        astsb_pkg::ADDR_TS_LO: rd_mux = ts_count[7:0]; // RQ1
        astsb_pkg::ADDR_TS_MID: rd_mux = ts_count[15:8]; // RQ2
        astsb_pkg::ADDR_TS_HI: rd_mux = ts_count[23:16]; // RQ3
        astsb_pkg::ADDR_POWER_UP_EVENT: rd_mux = por_word; // RQ4
        astsb_pkg::ADDR_FEAT_STATUS: rd_mux = feat_ff; // RQ5
        astsb_pkg::ADDR_IRQ_STATUS: rd_mux = astsb_pkg::DATA_W'(irq_stat_ff);
        astsb_pkg::ADDR_IRQ_ENABLE: rd_mux = astsb_pkg::DATA_W'(irq_en_ff);
        default: rd_mux = astsb_pkg::RST_ZERO;
      endcase
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_ff <= astsb_pkg::RST_ZERO;
    end else begin
      rdata_ff <= bus_req.rd ? rd_mux : astsb_pkg::RST_ZERO;
    end
  end

  assign bus_rdata = rdata_ff;

  // =====================================================================
  // checks
  a_por_read_clear: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
    (rd_por && !soft_rst) |=> !por_ff)
    else $error("power-up flag survived its read");

  a_por_read_data: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
    rd_por |=> (bus_rdata == {7'h00, $past(por_ff)}))
    else $error("power-up register read returned wrong value");

  a_feat_read_clear: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    (rd_feat && !feat_in.error && !feat_in.no_motion && !feat_in.any_motion)
    |=> (feat_ff == 8'h00))
    else $error("feature status not cleared by read");

  a_feat_bit_map: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    (feat_in.any_motion || feat_in.no_motion || feat_in.error) |=>
    (feat_ff[5] == $past(feat_in.any_motion) || $past(feat_ff[5]))
    && (feat_ff[6] || !$past(feat_in.no_motion))
    && (feat_ff[7] || !$past(feat_in.error)) && (feat_ff[4:0] == 5'h00))
    else $error("feature event landed in wrong bit");

  a_feat_read_data: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    rd_feat |=> (bus_rdata == $past(feat_ff)))
    else $error("feature status read returned wrong value");

  a_drdy_read_clear: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
    (rd_acc && !sample_in.valid) |=> !sample_ready)
    else $error("sample-ready not cleared by data read");

  a_drdy_set: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
    sample_in.valid |=> sample_ready ##0 (acc_ff[0] == $past(sample_in.x[7:0])))
    else $error("sample not captured or ready not raised");

  a_acc_byte_order: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
    (bus_req.rd && bus_req.addr == astsb_pkg::ADDR_ACC_Y_HI) |=>
    (bus_rdata == $past(acc_ff[3])))
    else $error("y high byte read from wrong place");

  a_acc_pair_hold: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
    sample_in.valid |=> ({acc_ff[5], acc_ff[4]} == $past(sample_in.z))
    && ({acc_ff[3], acc_ff[2]} == $past(sample_in.y)))
    else $error("z pair not stored low byte first");

  a_ts_read_data: assert property (@(posedge clock) disable iff (sys_rst) // RQ1
    (bus_req.rd && bus_req.addr == astsb_pkg::ADDR_TS_LO) |=>
    (bus_rdata == $past(ts_count[7:0])))
    else $error("timestamp low byte read wrong");

  a_irq_level: assert property (@(posedge clock) disable iff (sys_rst)
    (irq_en_ff[astsb_pkg::IRQ_ANYMO_BIT] && feat_in.any_motion && !wr_enable) |=> irq)
    else $error("enabled event did not raise interrupt");

  // =====================================================================
  // checks on stored state and on the x low byte read
  a_ts_soft_restart: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
    soft_rst |=> (ts_count == '0))
    else $error("timestamp not restarted by soft reset");

  a_por_soft_set: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
    soft_rst |=> por_ff)
    else $error("power-up flag not set by soft reset");

  a_por_flag_hold: assert property (@(posedge clock) disable iff (sys_rst) // RQ4
    (por_ff && !rd_por) |=> por_ff)
    else $error("power-up flag dropped without a read");

  a_feat_sticky_bits: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    !rd_feat |=> ((feat_ff & $past(feat_ff)) == $past(feat_ff)))
    else $error("feature flag dropped without a read");

  a_feat_err_set: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    feat_in.error |=> feat_ff[astsb_pkg::FEAT_ERR_BIT])
    else $error("error event not latched");

  a_feat_nomo_set: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    feat_in.no_motion |=> feat_ff[astsb_pkg::FEAT_NOMO_BIT])
    else $error("no-motion event not latched");

  a_feat_anymo_set: assert property (@(posedge clock) disable iff (sys_rst) // RQ5
    feat_in.any_motion |=> feat_ff[astsb_pkg::FEAT_ANYMO_BIT])
    else $error("any-motion event not latched");

  a_drdy_flag_hold: assert property (@(posedge clock) disable iff (sys_rst) // RQ6
    (sample_ready && !rd_acc) |=> sample_ready)
    else $error("sample-ready dropped without a data read");

  a_acc_x_pair: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
    sample_in.valid |=> ({acc_ff[1], acc_ff[0]} == $past(sample_in.x)))
    else $error("x pair not stored low byte first");

  a_acc_x_lo_read: assert property (@(posedge clock) disable iff (sys_rst) // RQ7
    (bus_req.rd && bus_req.addr == astsb_pkg::ADDR_ACC_X_LO) |=>
    (bus_rdata == $past(acc_ff[0])))
    else $error("x low byte read from wrong place");

  // =====================================================================
  // checks on read data and interrupt state
  // a stale word left on the read port would be taken by a host that
  // samples late, so idle cycles must read as zero
  a_ts_mid_read: assert property (@(posedge clock) disable iff (sys_rst) // RQ2
    (bus_req.rd && bus_req.addr == astsb_pkg::ADDR_TS_MID) |=>
    (bus_rdata == $past(ts_count[15:8])))
    else $error("timestamp middle byte read wrong");

  a_ts_high_read: assert property (@(posedge clock) disable iff (sys_rst) // RQ3
    (bus_req.rd && bus_req.addr == astsb_pkg::ADDR_TS_HI) |=>
    (bus_rdata == $past(ts_count[23:16])))
    else $error("timestamp high byte read wrong");

  a_rdata_idle_zero: assert property (@(posedge clock) disable iff (sys_rst)
    !bus_req.rd |=> (bus_rdata == astsb_pkg::RST_ZERO))
    else $error("read data present without a read");

  a_irq_clear_bit: assert property (@(posedge clock) disable iff (sys_rst)
    (wr_clear && bus_req.wdata[astsb_pkg::IRQ_DRDY_BIT] && !sample_in.valid)
    |=> !irq_stat_ff[astsb_pkg::IRQ_DRDY_BIT])
    else $error("sample status bit survived its clear");

  a_irq_enable_write: assert property (@(posedge clock) disable iff (sys_rst)
    wr_enable |=> (irq_en_ff == $past(bus_req.wdata[astsb_pkg::IRQ_W-1:0])))
    else $error("interrupt enable write not stored");

endmodule

`default_nettype wire

// file: test/astsb_host.sv
// host-side model that drives the register bus of the sample/time/status bank
`timescale 1ns/10ps
`default_nettype none

module astsb_host (
  input wire logic clock, // system clock
  output var astsb_pkg::astsb_req_t bus_req, // register request
  input wire logic [astsb_pkg::DATA_W-1:0] bus_rdata // read data
);
  initial bus_req = '0;

  // ============================================================
  // bus cycles
  // the bank never stalls, so each strobe lasts exactly one cycle
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
endmodule

`default_nettype wire

// file: test/astsb_bank_tb.sv
// self-checking bench for the sample/time/status register bank
`timescale 1ns/10ps
`default_nettype none

module astsb_bank_tb;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  astsb_pkg::astsb_req_t bus_req;
  logic [7:0] bus_rdata;
  astsb_pkg::astsb_sample_t sample_in = '0;
  astsb_pkg::astsb_feat_t feat_in = '0;
  logic sample_ready;
  logic irq;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic [7:0] r0;
  logic [7:0] r1;
  logic [47:0] smp_bytes = 48'h9ABC_5678_1234;

  always #5 clock = ~clock;

  // one timestamp count per clock keeps the high-byte carry within the run
  astsb_bank #(.TS_LSB_PS(10000)) dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata),
    .sample_in(sample_in),
    .feat_in(feat_in),
    .sample_ready(sample_ready),
    .irq(irq)
  );

  astsb_host host (
    .clock(clock),
    .bus_req(bus_req),
    .bus_rdata(bus_rdata)
  );

  // ============================================================
  // comparisons and closing
  task automatic check8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    host.read_reg(a, rv);
    check8(nm, e, rv);
  endtask

  task automatic settle();
    @(posedge clock);
    #1;
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // whole run needs about 66000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 90000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ============================================================
  // scenarios
  task automatic test_reset_values();
    check1("sample_ready after reset", 1'b0, sample_ready);
    check1("irq after reset", 1'b0, irq);
    rd_chk(8'h1B, 8'h01, "power_up_event");
    rd_chk(8'h1B, 8'h00, "power_up_event after read");
    rd_chk(8'h1C, 8'h00, "feature_irq_status reset");
    for (int a = 8'h12; a < 8'h18; a++) begin
      rd_chk(8'(a), 8'h00, "accel byte reset");
    end
    host.write_reg(8'h13, 8'hA5);
    rd_chk(8'h13, 8'h00, "accel_x_high_byte after write");
    rd_chk(8'hFF, 8'h00, "unmapped read");
    rd_chk(8'h31, 8'h00, "irq clear read");
  endtask

  task automatic test_sample();
    host.write_reg(8'h31, 8'h1F);
    @(posedge clock);
    sample_in <= '{valid: 1'b1, x: 16'h1234, y: 16'h5678, z: 16'h9ABC};
    @(posedge clock);
    sample_in.valid <= 1'b0;
    settle();
    check1("sample_ready after sample", 1'b1, sample_ready);
    // high z byte first: the flag must drop on any data byte, not only x low
    for (int i = 5; i >= 0; i--) begin
      rd_chk(8'(8'h12 + i), smp_bytes[8*i+:8], "accel byte");
      if (i == 5) begin
        check1("sample_ready after read", 1'b0, sample_ready);
      end
    end
    rd_chk(8'h30, 8'h01, "irq status sample");
    check1("irq masked", 1'b0, irq);
    host.write_reg(8'h32, 8'h01);
    settle();
    check1("irq enabled", 1'b1, irq);
    rd_chk(8'h32, 8'h01, "irq enable readback");
    host.write_reg(8'h31, 8'h01);
    settle();
    check1("irq cleared", 1'b0, irq);
    rd_chk(8'h30, 8'h00, "irq status cleared");
  endtask

  task automatic test_features();
    for (int b = 5; b < 8; b++) begin
      @(posedge clock);
      feat_in <= astsb_pkg::astsb_feat_t'(3'b001 << (b - 5));
      @(posedge clock);
      feat_in <= '0;
      rd_chk(8'h1C, 8'h01 << b, "feature single flag");
    end
    @(posedge clock);
    feat_in <= '1;
    @(posedge clock);
    feat_in <= '0;
    rd_chk(8'h1C, 8'hE0, "feature all flags");
    rd_chk(8'h1C, 8'h00, "feature after read");
    rd_chk(8'h30, 8'h0E, "irq status features");
    host.write_reg(8'h32, 8'h0E);
    settle();
    check1("irq on features", 1'b1, irq);
    host.write_reg(8'h31, 8'h0E);
    settle();
    check1("irq features cleared", 1'b0, irq);
    @(posedge clock);
    feat_in <= '{error: 1'b0, no_motion: 1'b0, any_motion: 1'b1};
    @(posedge clock);
    feat_in <= '0;
    settle();
    check1("irq on enabled any-motion", 1'b1, irq);
    rd_chk(8'h1C, 8'h20, "feature any-motion only");
    host.write_reg(8'h31, 8'h0E);
    settle();
    check1("irq any-motion cleared", 1'b0, irq);
  endtask

  task automatic test_soft_reset();
    host.write_reg(8'h33, 8'hA5);
    rd_chk(8'h1B, 8'h00, "power_up_event wrong key");
    host.write_reg(8'h33, 8'h5A);
    rd_chk(8'h1B, 8'h01, "power_up_event soft reset");
    rd_chk(8'h1B, 8'h00, "power_up_event cleared");
    rd_chk(8'h30, 8'h10, "irq status soft reset");
  endtask

  // successive reads are taken 2 cycles apart plus the idle cycles between them
  task automatic test_timestamp();
    host.read_reg(8'h18, r0);
    host.read_reg(8'h18, r1);
    check8("timestamp low step", r0 + 8'h02, r1);
    host.read_reg(8'h18, r0);
    repeat (254) @(posedge clock);
    host.read_reg(8'h18, r1);
    check8("timestamp low wrap", r0, r1);
    host.read_reg(8'h19, r0);
    repeat (254) @(posedge clock);
    host.read_reg(8'h19, r1);
    check8("timestamp mid weight", r0 + 8'h01, r1);
    host.read_reg(8'h1A, r0);
    repeat (65534) @(posedge clock);
    host.read_reg(8'h1A, r1);
    check8("timestamp high weight", r0 + 8'h01, r1);
  endtask

  // ============================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    settle();
    test_reset_values();
    test_sample();
    test_features();
    test_soft_reset();
    test_timestamp();
    tally_and_finish();
  end
endmodule

`default_nettype wire
